// ==== saao_consts.svh ====
// Timing, length and reset constants for the subtract / AND execution unit
`ifndef SAAO_CONSTS_SVH
`define SAAO_CONSTS_SVH

// ----------------------------------------------------------------------
// Instruction lengths in bytes
// ----------------------------------------------------------------------
`define SAAO_LEN_1 3'h1
`define SAAO_LEN_2 3'h2
`define SAAO_LEN_3 3'h3

// ----------------------------------------------------------------------
// Instruction clock counts (fast area or no data access / other area)
// ----------------------------------------------------------------------
`define SAAO_CLK_4 4'h4
`define SAAO_CLK_5 4'h5
`define SAAO_CLK_6 4'h6
`define SAAO_CLK_8 4'h8
`define SAAO_CLK_9 4'h9

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SAAO_RST_BYTE 8'h00
`define SAAO_RST_ADDR 16'h0000
`define SAAO_RST_FLAG 1'h0

`endif

// ==== saao_exec.sv ====
// Execution unit for the subtract, subtract-with-borrow and AND group
`timescale 1ns/1ps
`include "saao_consts.svh"
module saao_exec #(
    parameter logic [15:0] SADDR_BASE = 16'hff00,
    parameter logic [15:0] FAST_LO = 16'hfc00,
    parameter logic [15:0] FAST_HI = 16'hfeff
) (
    // Clock and reset
    input  wire logic CLK,
    input  wire logic RESET,
    // Instruction issue
    input  wire logic START,
    input  wire saao_pkg::saao_op_t OP,
    input  wire saao_pkg::saao_mode_t MODE,
    input  wire logic [7:0] ACC,
    input  wire logic [7:0] REG_VAL,
    input  wire logic [7:0] IMM,
    input  wire logic [7:0] SADDR_OFS,
    input  wire logic [15:0] ADDR16,
    input  wire logic [15:0] PTR_PAIR,
    input  wire logic [7:0] REG_B,
    input  wire logic [7:0] REG_C,
    output wire logic BUSY,
    // Memory read port
    output logic MEM_RD,
    output logic [15:0] MEM_ADDR,
    input  wire logic [7:0] MEM_RDATA,
    // Result write-back
    output logic DONE,
    output logic [7:0] RESULT,
    output logic ACC_WE,
    output logic REG_WE,
    output logic MEM_WE,
    // Instruction attributes
    output logic [2:0] INSTR_BYTES,
    output logic [3:0] INSTR_CLOCKS,
    // Flags
    output logic ZERO_FLAG,
    output logic AUX_CARRY_FLAG,
    output logic CARRY_FLAG
);
    import saao_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    saao_state_t state_q;
    saao_op_t op_q;
    saao_mode_t mode_q;
    logic [7:0] acc_q;
    logic [7:0] reg_q;
    logic [7:0] imm_q;
    logic [7:0] opnd_q;
    logic [3:0] count_q;
    logic cap_q;
    logic [2:0] len_d;
    logic [3:0] clk_lo_d;
    logic [3:0] clk_hi_d;
    logic mem_acc_d;
    logic [15:0] addr_d;
    logic fast_d;
    logic [3:0] clocks_d;
    logic [7:0] op_x;
    logic [7:0] op_y;
    logic borrow_in;
    logic [7:0] diff;
    logic bor_lo;
    logic bor_hi;
    logic [7:0] res_d;
    logic is_and;
    logic issue;
    logic finish;

    // ------------------------------------------------------------------
    // Length, clock and addressing table per form
    // ------------------------------------------------------------------
    always_comb begin
        len_d = `SAAO_LEN_2;
        clk_lo_d = `SAAO_CLK_4;
        clk_hi_d = `SAAO_CLK_4;
        mem_acc_d = 1'b0;
        addr_d = ADDR16;
        unique case (MODE)
            SAAO_M_A_IMM: begin
                len_d = `SAAO_LEN_2;
            end
            SAAO_M_SADDR_IMM: begin
                len_d = `SAAO_LEN_3;
                clk_lo_d = `SAAO_CLK_6;
                clk_hi_d = `SAAO_CLK_8;
                mem_acc_d = 1'b1;
                addr_d = 16'(SADDR_BASE + {8'h00, SADDR_OFS});
            end
            SAAO_M_A_R, SAAO_M_R_A: begin
                len_d = `SAAO_LEN_2;
            end
            SAAO_M_A_SADDR: begin
                len_d = `SAAO_LEN_2;
                clk_hi_d = `SAAO_CLK_5;
                mem_acc_d = 1'b1;
                addr_d = 16'(SADDR_BASE + {8'h00, SADDR_OFS});
            end
            SAAO_M_A_ABS: begin
                len_d = `SAAO_LEN_3;
                clk_lo_d = `SAAO_CLK_8;
                clk_hi_d = `SAAO_CLK_9;
                mem_acc_d = 1'b1;
                addr_d = ADDR16;
            end
            SAAO_M_A_PTR: begin
                len_d = `SAAO_LEN_1;
                clk_hi_d = `SAAO_CLK_5;
                mem_acc_d = 1'b1;
                addr_d = PTR_PAIR;
            end
            SAAO_M_A_PTR_D, SAAO_M_A_PTR_B, SAAO_M_A_PTR_C: begin
                len_d = `SAAO_LEN_2;
                clk_lo_d = `SAAO_CLK_8;
                clk_hi_d = `SAAO_CLK_9;
                mem_acc_d = 1'b1;
                if (MODE == SAAO_M_A_PTR_D) begin
                    addr_d = 16'(PTR_PAIR + {8'h00, IMM});
                end else if (MODE == SAAO_M_A_PTR_B) begin
                    addr_d = 16'(PTR_PAIR + {8'h00, REG_B});
                end else begin
                    addr_d = 16'(PTR_PAIR + {8'h00, REG_C});
                end
            end
            default: begin
                len_d = `SAAO_LEN_2;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Area select for the clock count; same table for every group
    // ------------------------------------------------------------------
    assign fast_d = !mem_acc_d || ((addr_d >= FAST_LO) && (addr_d <= FAST_HI));
    assign clocks_d = fast_d ? clk_lo_d : clk_hi_d;

    // ------------------------------------------------------------------
    // Operand selection from the captured instruction
    // ------------------------------------------------------------------
    assign op_x = (mode_q == SAAO_M_SADDR_IMM) ? opnd_q :
                  (mode_q == SAAO_M_R_A) ? reg_q : acc_q;
    assign op_y = (mode_q == SAAO_M_A_IMM || mode_q == SAAO_M_SADDR_IMM) ? imm_q :
                  (mode_q == SAAO_M_A_R) ? reg_q :
                  (mode_q == SAAO_M_R_A) ? acc_q : opnd_q;

    // ------------------------------------------------------------------
    // Arithmetic: two slices so the bit-3 borrow is visible
    // ------------------------------------------------------------------
    assign is_and = (op_q == SAAO_OP_AND);
    assign borrow_in = (op_q == SAAO_OP_SUBB) && CARRY_FLAG;

    saao_nib_sub #(
        .W(4)
    ) u_lo (
        .a(op_x[3:0]),
        .b(op_y[3:0]),
        .bin(borrow_in),
        .diff(diff[3:0]),
        .bout(bor_lo)
    );

    saao_nib_sub #(
        .W(4)
    ) u_hi (
        .a(op_x[7:4]),
        .b(op_y[7:4]),
        .bin(bor_lo),
        .diff(diff[7:4]),
        .bout(bor_hi)
    );

    assign res_d = is_and ? (op_x & op_y) : diff;

    // ------------------------------------------------------------------
    // Sequencer strobes
    // ------------------------------------------------------------------
    assign BUSY = (state_q == SAAO_S_RUN);
    assign issue = START && (state_q == SAAO_S_IDLE);
    assign finish = (state_q == SAAO_S_RUN) && (count_q == 4'h1);

    // ------------------------------------------------------------------
    // State and clock counter: one count per CLK cycle
    // ------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RESET) begin
            state_q <= SAAO_S_IDLE;
            count_q <= 4'h0;
        end else if (issue) begin
            state_q <= SAAO_S_RUN;
            count_q <= clocks_d - 4'h1;
        end else if (finish) begin
            state_q <= SAAO_S_IDLE;
            count_q <= 4'h0;
        end else if (state_q == SAAO_S_RUN) begin
            count_q <= count_q - 4'h1;
        end
    end

    // ------------------------------------------------------------------
    // Instruction capture
    // ------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RESET) begin
            op_q <= SAAO_OP_SUB;
            mode_q <= SAAO_M_A_IMM;
            acc_q <= `SAAO_RST_BYTE;
            reg_q <= `SAAO_RST_BYTE;
            imm_q <= `SAAO_RST_BYTE;
            INSTR_BYTES <= 3'h0;
            INSTR_CLOCKS <= 4'h0;
        end else if (issue) begin
            op_q <= OP;
            mode_q <= MODE;
            acc_q <= ACC;
            reg_q <= REG_VAL;
            imm_q <= IMM;
            INSTR_BYTES <= len_d;
            INSTR_CLOCKS <= clocks_d;
        end
    end

    // ------------------------------------------------------------------
    // Memory operand read: strobe one cycle, data taken a cycle later
    // ------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RESET) begin
            MEM_RD <= 1'b0;
            MEM_ADDR <= `SAAO_RST_ADDR;
            cap_q <= 1'b0;
            opnd_q <= `SAAO_RST_BYTE;
        end else begin
            MEM_RD <= issue && mem_acc_d;
            cap_q <= MEM_RD;
            if (issue) begin
                MEM_ADDR <= addr_d;
            end
            if (cap_q) begin
                opnd_q <= MEM_RDATA;
            end
        end
    end

    // ------------------------------------------------------------------
    // Write-back strobes and result
    // ------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RESET) begin
            DONE <= 1'b0;
            ACC_WE <= 1'b0;
            REG_WE <= 1'b0;
            MEM_WE <= 1'b0;
            RESULT <= `SAAO_RST_BYTE;
        end else begin
            DONE <= finish;
            ACC_WE <= finish && (mode_q != SAAO_M_R_A) && (mode_q != SAAO_M_SADDR_IMM);
            REG_WE <= finish && (mode_q == SAAO_M_R_A);
            MEM_WE <= finish && (mode_q == SAAO_M_SADDR_IMM);
            if (finish) begin
                RESULT <= res_d;
            end
        end
    end

    // ------------------------------------------------------------------
    // Flags: AND touches zero only, subtract forms touch all three
    // ------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RESET) begin
            ZERO_FLAG <= `SAAO_RST_FLAG;
            AUX_CARRY_FLAG <= `SAAO_RST_FLAG;
            CARRY_FLAG <= `SAAO_RST_FLAG;
        end else if (finish) begin
            ZERO_FLAG <= (res_d == 8'h00);
            if (!is_and) begin
                AUX_CARRY_FLAG <= bor_lo;
                CARRY_FLAG <= bor_hi;
            end
        end
    end

endmodule : saao_exec

// ==== saao_exec_properties.sv ====
// Concurrent checks on the ports of the execution unit
`timescale 1ns/1ps
module saao_exec_checker
    import saao_pkg::*;
(
    // Observed ports
    input wire logic CLK,
    input wire logic RESET,
    input wire logic START,
    input wire saao_pkg::saao_op_t OP,
    input wire saao_pkg::saao_mode_t MODE,
    input wire logic [15:0] PTR_PAIR,
    input wire logic [7:0] REG_B,
    input wire logic BUSY,
    input wire logic MEM_RD,
    input wire logic [15:0] MEM_ADDR,
    input wire logic DONE,
    input wire logic ACC_WE,
    input wire logic REG_WE,
    input wire logic MEM_WE,
    input wire logic [2:0] INSTR_BYTES,
    input wire logic [3:0] INSTR_CLOCKS,
    input wire logic [7:0] RESULT,
    input wire logic ZERO_FLAG,
    input wire logic AUX_CARRY_FLAG,
    input wire logic CARRY_FLAG
);
    // ------------------------------------------------------------------
    // Helper state: cycles since issue and the issued operation
    // ------------------------------------------------------------------
    wire logic issue = START && !BUSY;
    logic [3:0] cnt_q;
    saao_op_t op_q;
    saao_mode_t mode_q;
    always_ff @(posedge CLK) begin
        if (RESET) begin
            cnt_q <= 4'h0;
        end else if (issue) begin
            cnt_q <= 4'h1;
        end else if (cnt_q != 4'h0 && cnt_q != 4'hf) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
    always_ff @(posedge CLK) begin
        if (issue) begin
            op_q <= OP;
            mode_q <= MODE;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);
    a_done_count: assert property (DONE |-> cnt_q == INSTR_CLOCKS)
        else $error("done not at the stated clock count");
    a_one_strobe: assert property (DONE |-> $onehot({ACC_WE, REG_WE, MEM_WE}))
        else $error("not exactly one write strobe");
    a_strobe_done: assert property ((ACC_WE || REG_WE || MEM_WE) |-> DONE)
        else $error("write strobe outside done");
    a_we_select: assert property (DONE |-> (REG_WE == (mode_q == SAAO_M_R_A))
        && (MEM_WE == (mode_q == SAAO_M_SADDR_IMM))) else $error("wrong destination");
    a_reg_timing: assert property (issue && MODE inside {SAAO_M_A_IMM, SAAO_M_A_R,
        SAAO_M_R_A} |=> INSTR_CLOCKS == 4'h4 && INSTR_BYTES == 3'h2 && !MEM_RD)
        else $error("register form timing wrong");
    a_ptr_read: assert property (issue && MODE == SAAO_M_A_PTR |=> MEM_RD
        && MEM_ADDR == $past(PTR_PAIR) && INSTR_BYTES == 3'h1) else $error("pointer read wrong");
    a_index_sum: assert property (issue && MODE == SAAO_M_A_PTR_B |=>
        MEM_ADDR == $past(PTR_PAIR) + 16'($past(REG_B))) else $error("indexed address wrong");
    a_and_keeps: assert property (DONE && op_q == SAAO_OP_AND |->
        $stable(AUX_CARRY_FLAG) && $stable(CARRY_FLAG)) else $error("logic op changed carries");
    a_zero_flag: assert property (DONE |-> ZERO_FLAG == (RESULT == 8'h00))
        else $error("zero flag wrong");
    a_busy_run: assert property (issue |=> BUSY [*3])
        else $error("busy dropped early");
    c_mem_write: cover property (DONE && MEM_WE);
    c_reg_write: cover property (DONE && REG_WE);
    c_ptr_read: cover property (issue && MODE == SAAO_M_A_PTR_C);
endmodule : saao_exec_checker

bind saao_exec saao_exec_checker i_chk (.CLK(CLK), .RESET(RESET), .START(START), .OP(OP),
    .MODE(MODE), .PTR_PAIR(PTR_PAIR), .REG_B(REG_B), .BUSY(BUSY), .MEM_RD(MEM_RD),
    .MEM_ADDR(MEM_ADDR), .DONE(DONE), .ACC_WE(ACC_WE), .REG_WE(REG_WE), .MEM_WE(MEM_WE),
    .INSTR_BYTES(INSTR_BYTES), .INSTR_CLOCKS(INSTR_CLOCKS), .RESULT(RESULT),
    .ZERO_FLAG(ZERO_FLAG), .AUX_CARRY_FLAG(AUX_CARRY_FLAG), .CARRY_FLAG(CARRY_FLAG));

// ==== saao_mem_model.sv ====
// Memory partner model for the subtract / AND execution unit
`timescale 1ns/1ps
module saao_mem_model (
    // Clock
    input wire logic clk,
    // Access from the unit
    input wire logic rd,
    input wire logic we,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    // Read data
    output logic [7:0] rdata
);
    logic [7:0] mem [0:65535];
    // Address pattern so every location reads back a known byte
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'(i) ^ 8'h5a;
        end
    end
    // Data valid only in the cycle after a read, churning otherwise
    always @(posedge clk) begin
        if (rd) begin
            rdata <= mem[addr];
        end else begin
            rdata <= ~rdata;
        end
        if (we) begin
            mem[addr] <= wdata;
        end
    end
endmodule : saao_mem_model

// ==== saao_nib_sub.sv ====
// Subtractor slice with borrow in and borrow out
`timescale 1ns/1ps
module saao_nib_sub #(
    parameter int W = 4
) (
    // Operands
    input  wire logic [W-1:0] a,
    input  wire logic [W-1:0] b,
    input  wire logic         bin,
    // Result
    output wire logic [W-1:0] diff,
    output wire logic         bout
);
    // ------------------------------------------------------------------
    // Difference one bit wider so the top bit is the borrow
    // ------------------------------------------------------------------
    logic [W:0] wide;
    assign wide = {1'b0, a} - {1'b0, b} - {{W{1'b0}}, bin};
    assign diff = wide[W-1:0];
    assign bout = wide[W];

endmodule : saao_nib_sub

// ==== saao_pkg.sv ====
// Types shared by the subtract / AND execution unit
package saao_pkg;

    // ------------------------------------------------------------------
    // Operation group
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SAAO_OP_SUB  = 3'h1,
        SAAO_OP_SUBB = 3'h2,
        SAAO_OP_AND  = 3'h4
    } saao_op_t;

    // ------------------------------------------------------------------
    // Addressing forms
    // ------------------------------------------------------------------
    typedef enum logic [9:0] {
        SAAO_M_A_IMM     = 10'h001,
        SAAO_M_SADDR_IMM = 10'h002,
        SAAO_M_A_R       = 10'h004,
        SAAO_M_R_A       = 10'h008,
        SAAO_M_A_SADDR   = 10'h010,
        SAAO_M_A_ABS     = 10'h020,
        SAAO_M_A_PTR     = 10'h040,
        SAAO_M_A_PTR_D   = 10'h080,
        SAAO_M_A_PTR_B   = 10'h100,
        SAAO_M_A_PTR_C   = 10'h200
    } saao_mode_t;

    // ------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SAAO_S_IDLE = 2'h1,
        SAAO_S_RUN  = 2'h2
    } saao_state_t;

endpackage : saao_pkg

// ==== tb.sv ====
// Self-checking bench for the subtract / AND execution unit
`timescale 1ns/1ps
module tb;
    import saao_pkg::*;
    // ------------------------------------------------------------------
    // Stimulus, observation and bookkeeping
    // ------------------------------------------------------------------
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic start = 1'b0;
    saao_op_t op = SAAO_OP_SUB;
    saao_mode_t mode = SAAO_M_A_IMM;
    logic [7:0] acc = 8'h00;
    logic [7:0] rv = 8'h00;
    logic [7:0] imm = 8'h00;
    logic [15:0] ptr = 16'h0000;
    logic busy, mem_rd, done, acc_we, reg_we, mem_we, zf, acf, cyf;
    logic [15:0] mem_addr;
    logic [7:0] mem_rdata, result;
    logic [2:0] ibytes;
    logic [3:0] iclocks;
    int n_fail = 0;
    int n_tests = 0;
    int cyc = 0;
    always #2.5 clk = ~clk;
    saao_exec i_dut (.CLK(clk), .RESET(reset), .START(start), .OP(op), .MODE(mode), .ACC(acc),
        .REG_VAL(rv), .IMM(imm), .SADDR_OFS(8'h20), .ADDR16(ptr), .PTR_PAIR(ptr),
        .REG_B(8'h03), .REG_C(8'h81), .BUSY(busy), .MEM_RD(mem_rd), .MEM_ADDR(mem_addr),
        .MEM_RDATA(mem_rdata), .DONE(done), .RESULT(result), .ACC_WE(acc_we), .REG_WE(reg_we),
        .MEM_WE(mem_we), .INSTR_BYTES(ibytes), .INSTR_CLOCKS(iclocks), .ZERO_FLAG(zf),
        .AUX_CARRY_FLAG(acf), .CARRY_FLAG(cyf));
    saao_mem_model i_mem (.clk(clk), .rd(mem_rd), .we(mem_we), .addr(mem_addr),
        .wdata(result), .rdata(mem_rdata));
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // One instruction: issue, wait for done, compare everything it returns
    task automatic run(input saao_op_t o, input saao_mode_t m, input logic [7:0] a,
            input logic [7:0] r, input logic [7:0] i, input logic [15:0] p, input logic [3:0] ek,
            input logic [2:0] eb, input logic [7:0] er, input logic [2:0] ef,
            input logic [2:0] ew);
        int k;
        k = 0;
        @(posedge clk);
        op <= o;
        mode <= m;
        acc <= a;
        rv <= r;
        imm <= i;
        ptr <= p;
        start <= 1'b1;
        do begin
            @(posedge clk);
            start <= 1'b0;
            k++;
            #1;
        end while (done !== 1'b1 && k < 12);
        check("clocks", 16'(k), 16'(ek));
        check("count", 16'(iclocks), 16'(ek));
        check("bytes", 16'(ibytes), 16'(eb));
        check("result", 16'(result), 16'(er));
        check("flags", 16'({zf, acf, cyf}), 16'(ef));
        check("strobes", 16'({acc_we, reg_we, mem_we}), 16'(ew));
    endtask : run
    task automatic t_sub;
        run(SAAO_OP_SUB, SAAO_M_A_IMM, 8'h10, 8'h00, 8'h01, 16'h0, 4'h4, 3'h2, 8'h0f, 3'h2, 3'h4);
        run(SAAO_OP_SUB, SAAO_M_SADDR_IMM, 8'h00, 8'h00, 8'h7b, 16'h0, 4'h8, 3'h3, 8'hff, 3'h3,
            3'h1);
        // The model stores the byte at the edge that ends the MEM_WE cycle
        @(posedge clk);
        #1;
        check("write back", 16'(i_mem.mem[16'hff20]), 16'h00ff);
        $display("test sub done");
    endtask : t_sub
    task automatic t_borrow;
        run(SAAO_OP_SUBB, SAAO_M_A_R, 8'h05, 8'h02, 8'h00, 16'h0, 4'h4, 3'h2, 8'h02, 3'h0, 3'h4);
        run(SAAO_OP_SUBB, SAAO_M_R_A, 8'h04, 8'h03, 8'h00, 16'h0, 4'h4, 3'h2, 8'hff, 3'h3, 3'h2);
        run(SAAO_OP_SUBB, SAAO_M_SADDR_IMM, 8'h00, 8'h00, 8'h0f, 16'h0, 4'h8, 3'h3, 8'hef, 3'h2,
            3'h1);
        @(posedge clk);
        #1;
        check("write back", 16'(i_mem.mem[16'hff20]), 16'h00ef);
        $display("test borrow done");
    endtask : t_borrow
    task automatic t_areas;
        run(SAAO_OP_SUB, SAAO_M_A_SADDR, 8'h80, 8'h0, 8'h0, 16'h0, 4'h5, 3'h2, 8'h91, 3'h3, 3'h4);
        run(SAAO_OP_SUB, SAAO_M_A_ABS, 8'h4a, 8'h0, 8'h0, 16'hfc10, 4'h8, 3'h3, 8'h0, 3'h4, 3'h4);
        run(SAAO_OP_SUB, SAAO_M_A_ABS, 8'h6e, 8'h0, 8'h0, 16'h1234, 4'h9, 3'h3, 8'h0, 3'h4, 3'h4);
        run(SAAO_OP_SUB, SAAO_M_A_PTR, 8'h5a, 8'h0, 8'h0, 16'hfe00, 4'h4, 3'h1, 8'h0, 3'h4, 3'h4);
        run(SAAO_OP_SUB, SAAO_M_A_PTR, 8'h5a, 8'h0, 8'h0, 16'h0100, 4'h5, 3'h1, 8'h0, 3'h4, 3'h4);
        run(SAAO_OP_SUB, SAAO_M_A_PTR_D, 8'h4b, 8'h0, 8'h11, 16'hfc00, 4'h8, 3'h2, 8'h0, 3'h4,
            3'h4);
        run(SAAO_OP_SUB, SAAO_M_A_PTR_B, 8'h58, 8'h0, 8'h0, 16'hfdff, 4'h8, 3'h2, 8'h0, 3'h4,
            3'h4);
        run(SAAO_OP_SUB, SAAO_M_A_PTR_C, 8'h00, 8'h0, 8'h0, 16'hfeff, 4'h9, 3'h2, 8'h26, 3'h3,
            3'h4);
        $display("test areas done");
    endtask : t_areas
    task automatic t_and;
        run(SAAO_OP_AND, SAAO_M_A_R, 8'hf0, 8'h0f, 8'h0, 16'h0, 4'h4, 3'h2, 8'h00, 3'h7, 3'h4);
        run(SAAO_OP_AND, SAAO_M_R_A, 8'h0f, 8'h3c, 8'h0, 16'h0, 4'h4, 3'h2, 8'h0c, 3'h3, 3'h2);
        run(SAAO_OP_AND, SAAO_M_A_PTR, 8'hff, 8'h0, 8'h0, 16'hfe00, 4'h4, 3'h1, 8'h5a, 3'h3,
            3'h4);
        $display("test and done");
    endtask : t_and
    // START held while BUSY must be ignored; only one instruction runs
    task automatic t_busy;
        @(posedge clk);
        op <= SAAO_OP_SUB;
        mode <= SAAO_M_A_IMM;
        acc <= 8'h09;
        imm <= 8'h09;
        start <= 1'b1;
        repeat (3) @(posedge clk);
        start <= 1'b0;
        @(posedge clk);
        #1;
        check("busy done", 16'({busy, done}), 16'h0001);
        check("busy result", 16'(result), 16'h0000);
        @(posedge clk);
        #1;
        check("no reissue", 16'({busy, done}), 16'h0000);
        $display("test busy done");
    endtask : t_busy
    // Cut a hang short
    always @(posedge clk) begin
        cyc++;
        if (cyc == 1000) begin
            n_fail++;
            complete_run();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        t_sub();
        t_borrow();
        t_areas();
        t_and();
        t_busy();
        complete_run();
    end
endmodule : tb
